/* File: bench/sppa_host.sv */
/* Host model: drives mode 0 frames and keeps the words read back.
   Assumes the device samples sck with its own faster clock. */
`timescale 1ns/1ps
`default_nettype none

module sppa_host (
    output logic cs_b,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    // ****************************************************************
    // Frames
    // ****************************************************************
    logic [15:0] rd [0:7];

    // Idle link: deselected, clock parked low
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end

    // Data is read late in the high phase, clear of the device's lag
    task automatic xfer(input logic [7:0] op, input int n,
        input logic [15:0] wd);
        int j;
        // Whole clock periods keep every change just after a clock edge
        #25 cs_b = 1'b0;
        for (j = 0; j < 8 + 16 * n; j++) begin
            mosi = (j < 8) ? op[7 - j] : wd[15 - (j - 8) % 16];
            #100 sck = 1'b1;
            #100;
            if (j >= 8) rd[(j - 8) / 16] = {rd[(j - 8) / 16][14:0], miso};
            sck = 1'b0;
        end
        #200 cs_b = 1'b1;
        mosi = ~mosi;
        #300;
    endtask
endmodule // sppa_host
`default_nettype wire

/* File: bench/sppa_monitor.sv */
/* Port checker of the pointer access path, bound to sppa_top.
   Assumes mode 0 host frames with sck far slower than sys_clk. */
`timescale 1ns/1ps
`default_nettype none
`include "sppa_defs.svh"

module sppa_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic mosi,
    input wire sppa_pkg::sppa_wr_t eng_wr,
    input wire logic miso,
    input wire logic miso_oe_b
);
    // ****************************************************************
    // Frame tracking
    // ****************************************************************
    logic sck_reg;
    logic [5:0] rise_reg;
    logic [7:0] op_reg;
    logic [3:0] fall_age_reg;
    logic [3:0] cs_age_reg;

    // Rises and ages saturate and the op byte holds after eight rises, so long frames never wrap
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_reg <= 1'b0;
            rise_reg <= 6'h00;
            op_reg <= 8'h00;
            fall_age_reg <= 4'h0;
            cs_age_reg <= 4'h0;
        end else begin
            sck_reg <= sck;
            if (cs_b) begin
                rise_reg <= 6'h00;
                cs_age_reg <= 4'h0;
            end else begin
                if (cs_age_reg != 4'hf) cs_age_reg <= cs_age_reg + 4'h1;
                if (sck && !sck_reg && rise_reg != 6'h3f) begin
                    rise_reg <= rise_reg + 6'h01;
                    if (rise_reg < 6'h08) op_reg <= {op_reg[6:0], mosi};
                end
            end
            if (!sck && sck_reg) fall_age_reg <= 4'h0;
            else if (fall_age_reg != 4'hf) fall_age_reg <= fall_age_reg + 4'h1;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_oe_on; $fell(cs_b) |-> ##[2:4] !miso_oe_b; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("output enable late after select");
    property p_oe_off; $rose(cs_b) |-> ##[2:4] miso_oe_b; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("output enable kept after release");
    property p_oe_hold; !cs_b && cs_age_reg == 4'hf |-> !miso_oe_b;
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("output enable lost in frame");
    property p_miso_edge;
        !cs_b && cs_age_reg > 4'h6 && $changed(miso) |-> fall_age_reg <= 4'h6;
    endproperty
    a_miso_edge: assert property (p_miso_edge)
        else $error("data out moved away from a falling clock");
    property p_op_quiet;
        !cs_b && cs_age_reg > 4'h6 && $changed(miso) |-> rise_reg >= 6'h08;
    endproperty
    a_op_quiet: assert property (p_op_quiet)
        else $error("data out moved during op byte");
    property p_inc_quiet; !cs_b && rise_reg == 6'h08 &&
        fall_age_reg == 4'h5 && op_reg == `SPPA_OP_INC |-> !miso;
    endproperty
    a_inc_quiet: assert property (p_inc_quiet)
        else $error("increment op sent data");
    property p_sel_quiet; !cs_b && rise_reg == 6'h08 && fall_age_reg ==
        4'h5 && (op_reg & 8'hfc) == `SPPA_OP_SEL_BASE |-> !miso;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet)
        else $error("select op sent data");
    property p_fwr_quiet; !cs_b && rise_reg > 6'h08 &&
        op_reg[7:6] == `SPPA_OP_FWR_TAG |-> !miso;
    endproperty
    a_fwr_quiet: assert property (p_fwr_quiet)
        else $error("fast write sent data");
endmodule // sppa_monitor

bind sppa_top sppa_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
    .cs_b(cs_b), .sck(sck), .mosi(mosi), .eng_wr(eng_wr), .miso(miso),
    .miso_oe_b(miso_oe_b));
`default_nettype wire

/* File: bench/sppa_top_test.sv */
/* Testbench of the pointer access path through the host model.
   Assumes the engine port can preload memory before host access. */
`timescale 1ns/1ps
`default_nettype none
`include "sppa_defs.svh"

module sppa_top_test;
    logic sys_clk;
    logic rst_b;
    logic cs_b;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe_b;
    sppa_pkg::sppa_wr_t eng_wr;
    int miscompares;
    int total_checks;
    int i;
    int k;
    logic [15:0] exp_base;

    sppa_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b),
        .sck(sck), .mosi(mosi), .eng_wr(eng_wr), .miso(miso),
        .miso_oe_b(miso_oe_b));
    sppa_host host (.cs_b(cs_b), .sck(sck), .mosi(mosi), .miso(miso));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Engine write, one pulse per word
    task automatic ew(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1 eng_wr = '{we: 1'b1, addr: a, data: d};
        @(posedge sys_clk);
        #1 eng_wr.we = 1'b0;
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Watchdog, far beyond the ten thousand cycles expected
    initial begin
        #2000000;
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        eng_wr = '0;
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge sys_clk);
        for (i = 0; i < 8; i++) begin
            ew(16'h0400 + i[15:0], 16'ha000 + i[15:0]);
            ew(16'h0100 + i[15:0], 16'hb000 + i[15:0]);
            ew(16'h05f8 + i[15:0], 16'hc000 + i[15:0]);
        end
        // Plain area: burst runs on; the closing fall of the last word
        // hands over a fifth word, so the pointer ends five past start
        host.xfer(8'hd8, 0, 16'h0000);
        host.xfer(8'h8b, 1, 16'h0100);
        host.xfer(8'h40, 4, 16'h0000);
        for (i = 0; i < 4; i++) chk(host.rd[i], 16'hb000 + i[15:0]);
        host.xfer(8'h3c, 1, 16'h0000);
        chk(host.rd[0], 16'h0105);
        host.xfer(8'h2c, 1, 16'h0000);
        chk(host.rd[0], 16'h0105);
        // Inside the table the burst sticks before a control word
        host.xfer(8'h8b, 1, `SPPA_TBL_BASE);
        host.xfer(8'h40, 6, 16'h0000);
        for (i = 0; i < 6; i++) begin
            chk(host.rd[i], 16'ha000 + 16'(i < 3 ? i : 3));
        end
        // Increment then read walks whole entries, up to the last one
        host.xfer(8'h8b, 1, 16'h03ff);
        for (k = 0; k < 3; k++) begin
            if (k == 2) host.xfer(8'h8b, 1, 16'h05fb);
            exp_base = (k == 2) ? 16'hc004 : 16'ha000 + 16'(4 * k);
            host.xfer(8'hd0, 0, 16'h0000);
            host.xfer(8'h40, 4, 16'h0000);
            for (i = 0; i < 4; i++) chk(host.rd[i], exp_base + i[15:0]);
        end
        // Each selectable pointer loads and reads back while enabled
        for (k = 0; k < 3; k++) begin
            host.xfer(8'hd9 + k[7:0], 0, 16'h0000);
            host.xfer(8'h8c + k[7:0], 1, 16'h0200 + k[15:0]);
            host.xfer(8'h3c, 1, 16'h0000);
            chk(host.rd[0], 16'h0200 + k[15:0]);
        end
        host.xfer(8'hd8, 0, 16'h0000);
        host.xfer(8'h8f, 1, 16'h0100);
        host.xfer(8'h2c, 1, 16'h0000);
        chk(host.rd[0], 16'h0100);
        host.xfer(8'h30, 1, 16'h0000);
        chk(host.rd[0], 16'h0200);
        // Unknown op is ignored, next frame decodes afresh
        host.xfer(8'hff, 1, 16'h0000);
        chk(host.rd[0], 16'h0000);
        for (k = 1; k < 4; k++) begin
            host.xfer(8'h80 + k[7:0], 1, 16'h1230 + k[15:0]);
            host.xfer(8'(k << 2), 1, 16'h0000);
            chk(host.rd[0], 16'h1230 + k[15:0]);
        end
        host.xfer(8'hbf, 1, 16'h5a5a);
        host.xfer(8'h8f, 1, 16'h003f);
        host.xfer(8'h40, 1, 16'h0000);
        chk(host.rd[0], 16'h5a5a);
        report_and_stop();
    end
endmodule // sppa_top_test
`default_nettype wire

/* File: core/sppa_defs.svh */
/*
 * Constants of the pointer and prefetch access path: op codes, register
 * numbers, descriptor table bounds and frame lengths.
 * Assumes it is included by bare name wherever these numbers are needed.
 */
`ifndef SPPA_DEFS_SVH
`define SPPA_DEFS_SVH

// ****************************************************************
// Op codes
// ****************************************************************
`define SPPA_OP_SEL_BASE 8'hd8
`define SPPA_OP_INC 8'hd0
`define SPPA_OP_READ 8'h40
`define SPPA_OP_FWR_TAG 2'b10
`define SPPA_OP_FRD_TAG 2'b00

// ****************************************************************
// Registers and table
// ****************************************************************
`define SPPA_REG_PTR_A 6'h0b
`define SPPA_REG_MAP 6'h0f
`define SPPA_REG_SPACE 16'h0040
`define SPPA_TBL_BASE 16'h0400
`define SPPA_TBL_LAST 16'h05ff
`define SPPA_PTR_RESET 16'h0000

// ****************************************************************
// Frame lengths in serial clocks
// ****************************************************************
`define SPPA_OP_BITS 4'd8
`define SPPA_WORD_BITS 5'd16

`endif

/* File: core/sppa_pkg.sv */
/*
 * Types of the pointer and prefetch access path.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sppa_pkg;

    // Serial engine state
    typedef enum logic [1:0] {
        SPPA_ST_OP,
        SPPA_ST_RD,
        SPPA_ST_WR,
        SPPA_ST_IGN
    } sppa_state_t;

    // One word write into the shared memory
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] data;
    } sppa_wr_t;

endpackage

/* File: core/sppa_ram.sv */
/*
 * Word memory holding registers and RAM, with registered read data.
 * Assumes both ports sit on sys_clk; port A wins a same-address clash.
 */
`timescale 1ns/1ps
`default_nettype none

module sppa_ram #(
    parameter int AW = 13
) (
    input wire logic sys_clk,
    input wire sppa_pkg::sppa_wr_t wr_a,
    input wire sppa_pkg::sppa_wr_t wr_b,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data
);

    logic [15:0] mem [0:(1<<AW)-1];

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Port B first so that the engine port wins a clash
    always_ff @(posedge sys_clk) begin
        if (wr_b.we) begin
            mem[wr_b.addr[AW-1:0]] <= wr_b.data;
        end
        if (wr_a.we) begin
            mem[wr_a.addr[AW-1:0]] <= wr_a.data;
        end
    end

    // Read data comes out of a register
    always_ff @(posedge sys_clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr[AW-1:0]];
        end
    end

endmodule // sppa_ram

`default_nettype wire

/* File: core/sppa_top.sv */
/*
 * Serial host access path: op code decode, address pointers, multi-word
 * reads with auto-increment and prefetch, fast register access.
 * Assumes chip select, serial clock and data in arrive asynchronously
 * and are far slower than sys_clk (mode 0: sample rise, shift on fall).
 */
// Functional notes
// - Every burst word addressed by enabled pointer
// - Burst continues while select held, clocks run
// - Increment pointer and prefetch after each fetch
// - Stall before descriptor control word, repeat word
// - Table spans base 0x0400 to 0x05FF
// - Op 0xD8 selects pointer at register 0x0B
// - Op 0x40 reads then auto-increments
// - Op 0xD0 adds one, no data
// - Fast read codes address registers 0-15
// - Fast write codes address registers 0-63
// - Ops 0xD9-0xDB select pointers 0x0C-0x0E
// - Control word every fourth table word
// - Each data word takes 16 clocks
`timescale 1ns/1ps
`default_nettype none
`include "sppa_defs.svh"

module sppa_top #(
    parameter int AW = 13,
    parameter logic [15:0] TBL_BASE = `SPPA_TBL_BASE,
    parameter logic [15:0] TBL_LAST = `SPPA_TBL_LAST
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic mosi,
    input wire sppa_pkg::sppa_wr_t eng_wr,
    output logic miso,
    output logic miso_oe_b
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // True where an address holds a descriptor control word
    function automatic logic is_ctl(input logic [15:0] a);
        logic [15:0] off;
        off = a - TBL_BASE;
        is_ctl = (a >= TBL_BASE) && (a <= TBL_LAST)
                 && (off[1:0] == 2'b00);
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic sck_prev_reg;

    // Two flops each, plus a third on sck for edge detect; no first stage feeds logic
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_reg <= 2'b11;
            sck_sync_reg <= 2'b00;
            mosi_sync_reg <= 2'b00;
            sck_prev_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], cs_b};
            sck_sync_reg <= {sck_sync_reg[0], sck};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi};
            sck_prev_reg <= sck_sync_reg[1];
        end
    end

    logic active;
    logic rise;
    logic fall;
    assign active = ~cs_sync_reg[1];
    assign rise = active & sck_sync_reg[1] & ~sck_prev_reg;
    assign fall = active & ~sck_sync_reg[1] & sck_prev_reg;

    // ****************************************************************
    // Op code shifter and decode
    // ****************************************************************
    sppa_pkg::sppa_state_t state_reg;
    logic [7:0] op_sh_reg;
    logic [3:0] bit_cnt_reg;
    logic [15:0] rx_reg;
    logic [5:0] wr_idx_reg;
    logic [7:0] op_next;
    logic op_done;
    logic go_sel;
    logic go_inc;
    logic go_burst;
    logic go_fread;
    logic go_fwrite;
    logic wr_go;

    assign op_next = {op_sh_reg[6:0], mosi_sync_reg[1]};
    assign op_done = rise && (state_reg == sppa_pkg::SPPA_ST_OP)
                     && (bit_cnt_reg == `SPPA_OP_BITS - 4'd1);
    assign wr_go = rise && (state_reg == sppa_pkg::SPPA_ST_WR)
                   && (bit_cnt_reg == 4'hf);

    // Decode the completed op code byte
    always_comb begin
        go_sel = op_done
                 && (op_next[7:2] == 6'(`SPPA_OP_SEL_BASE >> 2));
        go_inc = op_done && (op_next == `SPPA_OP_INC);
        go_burst = op_done && (op_next == `SPPA_OP_READ);
        go_fread = op_done && (op_next[7:6] == `SPPA_OP_FRD_TAG)
                   && (op_next[1:0] == 2'b00);
        go_fwrite = op_done && (op_next[7:6] == `SPPA_OP_FWR_TAG);
    end

    // Frame sequencing; unknown op codes just idle until select drops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= sppa_pkg::SPPA_ST_OP;
            op_sh_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            rx_reg <= 16'h0000;
            wr_idx_reg <= 6'h00;
        end else if (!active) begin
            state_reg <= sppa_pkg::SPPA_ST_OP;
            bit_cnt_reg <= 4'h0;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            case (state_reg)
                sppa_pkg::SPPA_ST_OP: begin
                    op_sh_reg <= op_next;
                    if (op_done) begin
                        bit_cnt_reg <= 4'h0;
                        wr_idx_reg <= op_next[5:0];
                        if (go_burst || go_fread) begin
                            state_reg <= sppa_pkg::SPPA_ST_RD;
                        end else if (go_fwrite) begin
                            state_reg <= sppa_pkg::SPPA_ST_WR;
                        end else begin
                            state_reg <= sppa_pkg::SPPA_ST_IGN;
                        end
                    end
                end
                sppa_pkg::SPPA_ST_WR: begin
                    rx_reg <= {rx_reg[14:0], mosi_sync_reg[1]};
                    if (wr_go) begin
                        state_reg <= sppa_pkg::SPPA_ST_IGN;
                    end
                end
                sppa_pkg::SPPA_ST_RD: begin
                    state_reg <= sppa_pkg::SPPA_ST_RD;
                end
                sppa_pkg::SPPA_ST_IGN: begin
                    state_reg <= sppa_pkg::SPPA_ST_IGN;
                end
                default: begin
                    state_reg <= sppa_pkg::SPPA_ST_IGN;
                end
            endcase
        end
    end

    logic [15:0] wr_word;
    assign wr_word = {rx_reg[14:0], mosi_sync_reg[1]};

    // ****************************************************************
    // Address pointers
    // ****************************************************************
    logic [15:0] ptr_reg [0:3];
    logic [1:0] sel_reg;
    logic burst_reg;
    logic consume;
    logic advance;
    logic [15:0] map;
    logic [15:0] map_inc;

    assign map = ptr_reg[sel_reg];
    assign map_inc = map + 16'd1;
    assign consume = fall && (state_reg == sppa_pkg::SPPA_ST_RD)
                     && (bit_cnt_reg == 4'h0);
    // No step and no prefetch when a control word comes next
    assign advance = consume && burst_reg && !is_ctl(map_inc);

    // Pointer select, increment and load
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                ptr_reg[i] <= `SPPA_PTR_RESET;
            end
            sel_reg <= 2'b00;
        end else begin
            if (go_sel) begin
                sel_reg <= op_next[1:0];
            end
            if (go_inc || advance) begin
                ptr_reg[sel_reg] <= map_inc;
            end
            if (wr_go && (wr_idx_reg == `SPPA_REG_MAP)) begin
                ptr_reg[sel_reg] <= wr_word;
            end else if (wr_go && (wr_idx_reg >= `SPPA_REG_PTR_A)
                         && (wr_idx_reg < `SPPA_REG_MAP)) begin
                ptr_reg[2'(wr_idx_reg - `SPPA_REG_PTR_A)] <= wr_word;
            end
        end
    end

    // Burst lasts from the read op until select drops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            burst_reg <= 1'b0;
        end else if (!active) begin
            burst_reg <= 1'b0;
        end else if (go_burst) begin
            burst_reg <= 1'b1;
        end else if (go_fread) begin
            burst_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Fetch pipeline and memory
    // ****************************************************************
    logic fetch_reg;
    logic [15:0] fetch_addr_reg;
    logic fetch_p2_reg;
    logic [15:0] addr_p2_reg;
    logic [15:0] pf_reg;
    logic [15:0] mem_rd;
    sppa_pkg::sppa_wr_t spi_wr;

    assign spi_wr.we = wr_go;
    assign spi_wr.addr = {10'h000, wr_idx_reg};
    assign spi_wr.data = wr_word;

    // Issue a fetch; the pointer registers are answered from flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_reg <= 1'b0;
            fetch_addr_reg <= 16'h0000;
            fetch_p2_reg <= 1'b0;
            addr_p2_reg <= 16'h0000;
            pf_reg <= 16'h0000;
        end else begin
            fetch_reg <= go_burst || go_fread || advance;
            if (go_burst) begin
                fetch_addr_reg <= map;
            end else if (go_fread) begin
                fetch_addr_reg <= {12'h000, op_next[5:2]};
            end else if (advance) begin
                fetch_addr_reg <= map_inc;
            end
            fetch_p2_reg <= fetch_reg;
            addr_p2_reg <= fetch_addr_reg;
            if (fetch_p2_reg) begin
                if (addr_p2_reg == {10'h000, `SPPA_REG_MAP}) begin
                    pf_reg <= map;
                end else if ((addr_p2_reg >= {10'h000, `SPPA_REG_PTR_A})
                             && (addr_p2_reg < {10'h000, `SPPA_REG_MAP})) begin
                    pf_reg <= ptr_reg[2'(addr_p2_reg
                                     - {10'h000, `SPPA_REG_PTR_A})];
                end else begin
                    pf_reg <= mem_rd;
                end
            end
        end
    end

    sppa_ram #(
        .AW(AW)
    ) u_ram (
        .sys_clk(sys_clk),
        .wr_a(eng_wr),
        .wr_b(spi_wr),
        .rd_en(fetch_reg),
        .rd_addr(fetch_addr_reg),
        .rd_data(mem_rd)
    );

    // ****************************************************************
    // Serial output
    // ****************************************************************
    logic [15:0] tx_reg;

    // Stalled bursts resend pf_reg, so the last word repeats
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_reg <= 16'h0000;
            miso <= 1'b0;
            miso_oe_b <= 1'b1;
        end else begin
            miso_oe_b <= ~active;
            if (!active) begin
                miso <= 1'b0;
            end else if (consume) begin
                miso <= pf_reg[15];
                tx_reg <= {pf_reg[14:0], 1'b0};
            end else if (fall && (state_reg == sppa_pkg::SPPA_ST_RD)) begin
                miso <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end

endmodule // sppa_top

`default_nettype wire
